// ---- verif/tps_panel_model.sv ----
// tps_panel_model: behavioural synchronous tft panel on the far side of tps_top.
// assumes the bench tells it the clock and sync polarities that it programs.
`timescale 1ns/100ps
module tps_panel_model (
    input wire logic pc_pol,
    input wire logic ln_pol,
    input wire logic fr_pol,
    input wire logic line_pulse_pin,
    input wire logic frame_marker_pin,
    input wire logic pixel_valid_pin,
    input wire logic panel_clock_pin,
    input wire logic [23:0] colour_bus
);
    logic [23:0] cap[$];
    int hcnt, lcnt, px_in_line, line_period, line_lead, last_len;
    int frame_lines, first_line, setup_err;
    logic ln_q, fr_q, ln_now, fr_now;
    realtime t_chg;

    // forget everything seen so far, used between scenarios
    task clear();
        cap.delete();
        hcnt = 0;
        lcnt = 0;
        px_in_line = 0;
        line_period = 0;
        line_lead = 0;
        last_len = 0;
        frame_lines = 0;
        first_line = -1;
        setup_err = 0;
        ln_q = 1'b0;
        fr_q = 1'b0;
    endtask : clear

    // time of last bus movement, to judge setup at the latch edge
    always @(colour_bus) t_chg = $realtime;

    // latch on the edge opposite to launch; a real panel has no other view
    always @(panel_clock_pin) begin
        if (panel_clock_pin === pc_pol) begin
            ln_now = (line_pulse_pin === ln_pol);
            fr_now = (frame_marker_pin === fr_pol);
            if (fr_now && !fr_q) begin
                frame_lines = lcnt;
                lcnt = 0;
                first_line = -1;
            end
            if (ln_now && !ln_q) begin
                line_period = hcnt + 1;
                hcnt = 0;
                lcnt++;
                if (px_in_line > 0) last_len = px_in_line;
                px_in_line = 0;
            end else begin
                hcnt++;
            end
            if (pixel_valid_pin === 1'b1) begin
                // less than a quarter pixel clock of setup means a wrong launch edge
                if ($realtime - t_chg < 100.0) setup_err++;
                if (px_in_line == 0) line_lead = hcnt;
                if (first_line < 0) first_line = lcnt - 1;
                cap.push_back(colour_bus);
                px_in_line++;
            end
            ln_q = ln_now;
            fr_q = fr_now;
        end
    end
endmodule : tps_panel_model

// ---- verif/tps_top_bench.sv ----
// tps_top_bench: self-checking bench for the tft panel timing output.
// assumes tps_top and tps_panel_model; clk 20 mhz, pixel clock 400 ns free running.
`timescale 1ns/100ps
module tps_top_bench;
    import tps_pkg::*;
    logic clk, rst, reg_wr, reg_rd, pixel_clock, pix_valid, pix_ready, feed_on;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [23:0] pix_data, colour_bus;
    logic line_pulse_pin, frame_marker_pin, pixel_valid_pin, panel_clock_pin;
    logic pc_pol, ln_pol, fr_pol;
    int n_mismatch, n_checks, cycles, src_idx;

    tps_top uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pixel_clock(pixel_clock), .pix_data(pix_data), .pix_valid(pix_valid),
        .pix_ready(pix_ready), .line_pulse_pin(line_pulse_pin),
        .frame_marker_pin(frame_marker_pin), .pixel_valid_pin(pixel_valid_pin),
        .panel_clock_pin(panel_clock_pin), .colour_bus(colour_bus));
    tps_panel_model panel (.pc_pol(pc_pol), .ln_pol(ln_pol), .fr_pol(fr_pol),
        .line_pulse_pin(line_pulse_pin), .frame_marker_pin(frame_marker_pin),
        .pixel_valid_pin(pixel_valid_pin), .panel_clock_pin(panel_clock_pin),
        .colour_bus(colour_bus));

    // clocks: pixel clock offset so its phase is unrelated to clk
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        pixel_clock = 1'b0;
        #37;
        forever #200 pixel_clock = ~pixel_clock;
    end

    function automatic logic [23:0] pat(input int i);
        pat = {i[7:0], ~i[7:0], i[7:0] ^ 8'h5A};
    endfunction : pat

    // expected panel word for each output depth
    function automatic logic [23:0] conv(input logic [23:0] p, input logic [1:0] d);
        case (d)
            2'h1: conv = {6'h0, p[23:18], p[15:10], p[7:2]};
            2'h2: conv = {8'h0, p[23:19], p[15:10], p[7:3]};
            default: conv = p;
        endcase
    endfunction : conv

    // pixel source: numbered pattern, advances only on an accepted word
    always @(posedge clk) begin
        if (rst) begin
            src_idx <= 0;
            pix_data <= pat(0);
        end else if (pix_valid && pix_ready) begin
            src_idx <= src_idx + 1;
            pix_data <= pat(src_idx + 1);
        end
        pix_valid <= feed_on;
    end

    // hang guard, well above the few thousand cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            n_mismatch++;
            $display("[ERR] %0t run timed out", $time);
            finish_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    task automatic do_reset();
        rst <= 1'b1;
        feed_on <= 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        panel.clear();
    endtask : do_reset

    // small raster: line 1+2 lead, 4 act, 2 trail; frame 1 lead, 2 act, 1 trail
    task automatic run_frames(input logic [7:0] ctrl, input logic feed);
        do_reset();
        pc_pol = ctrl[3];
        ln_pol = ctrl[1];
        fr_pol = ctrl[2];
        reg_write(TPS_ADDR_HACT, 32'h0001_0004);
        reg_write(TPS_ADDR_HGAP, 32'h0002_0003);
        reg_write(TPS_ADDR_VACT, 32'h0001_0002);
        reg_write(TPS_ADDR_VGAP, 32'h0001_0001);
        feed_on <= feed;
        repeat (20) @(posedge clk);
        #1;
        check({31'h0, pix_ready}, {31'h0, ~feed});
        reg_write(TPS_ADDR_CTRL, {24'h0, ctrl});
        repeat (800) @(posedge clk);
        #1;
    endtask : run_frames

    task automatic scen_regs();
        logic [31:0] d;
        do_reset();
        reg_read(TPS_ADDR_CTRL, d);
        check(d, 32'h0000_00C8);
        reg_read(TPS_ADDR_HACT, d);
        check(d, 32'h0060_0280);
        reg_read(TPS_ADDR_VGAP, d);
        check(d, 32'h000B_0022);
        reg_read(8'h18, d);
        check(d, 32'h0);
        reg_write(TPS_ADDR_HGAP, 32'h0002_0003);
        reg_read(TPS_ADDR_HGAP, d);
        check(d, 32'h0002_0003);
    endtask : scen_regs

    task automatic scen_frames(input logic [7:0] ctrl);
        logic [31:0] d;
        run_frames(ctrl, 1'b1);
        if (ctrl[6]) begin
            check(32'(panel.line_period), 32'h9);
            check(32'(panel.line_lead), 32'h3);
            check(32'(panel.last_len), 32'h4);
            check(32'(panel.first_line), 32'h1);
            check(32'(panel.frame_lines), 32'h4);
        end else begin
            check({31'h0, line_pulse_pin}, {31'h0, ~ln_pol});
            check({31'h0, frame_marker_pin}, {31'h0, ~fr_pol});
        end
        check(32'(panel.setup_err), 32'h0);
        for (int i = 0; i < 16; i++) begin
            check({8'h0, panel.cap[i]}, {8'h0, conv(pat(i), ctrl[5:4])});
        end
        reg_read(TPS_ADDR_STAT, d);
        check({30'h0, d[17:16]}, 32'h2);
    endtask : scen_frames

    // empty source: black keeps flowing, underrun flag sticks until cleared
    task automatic scen_underrun();
        logic [31:0] d;
        run_frames(8'hC9, 1'b0);
        check({8'h0, panel.cap[0]}, 32'h0);
        reg_read(TPS_ADDR_STAT, d);
        check({30'h0, d[17:16]}, 32'h3);
        reg_write(TPS_ADDR_CTRL, 32'h0000_00C8);
        reg_write(TPS_ADDR_STAT, 32'h0001_0000);
        repeat (10) @(posedge clk);
        #1;
        check({31'h0, pixel_valid_pin}, 32'h0);
        check({8'h0, colour_bus}, 32'h0);
        check({31'h0, line_pulse_pin}, 32'h1);
        reg_read(TPS_ADDR_STAT, d);
        check({30'h0, d[17:16]}, 32'h0);
    endtask : scen_underrun

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test

    initial begin
        rst = 1'b1;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        feed_on = 1'b0;
        pc_pol = 1'b1;
        ln_pol = 1'b0;
        fr_pol = 1'b0;
        scen_regs();
        scen_frames(8'hC9);
        scen_frames(8'hD7);
        scen_frames(8'h29);
        scen_underrun();
        finish_test();
    end
endmodule : tps_top_bench

// ---- verilog/tps_fifo.sv ----
// tps_fifo: flip-flop fifo with valid/ready on both sides.
// assumes both sides run on clk; out_data valid while out_valid.
`timescale 1ns/100ps
module tps_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } tps_ff_s;

    tps_ff_s q_ff;
    tps_ff_s nxt_q;
    logic push;
    logic pop;

    // full and empty straight from the count
    assign in_ready = (q_ff.cnt != (AW+1)'(DEPTH));
    assign out_valid = (q_ff.cnt != '0);
    assign out_data = q_ff.mem[q_ff.rp];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // pointers wrap at depth, so depth need not be a power of two
    always_comb begin
        nxt_q = q_ff;
        if (push) begin
            nxt_q.mem[q_ff.wp] = in_data;
            nxt_q.wp = (q_ff.wp == AW'(DEPTH-1)) ? '0 : q_ff.wp + 1'b1;
        end
        if (pop) begin
            nxt_q.rp = (q_ff.rp == AW'(DEPTH-1)) ? '0 : q_ff.rp + 1'b1;
        end
        if (push && !pop) begin
            nxt_q.cnt = q_ff.cnt + 1'b1;
        end else if (pop && !push) begin
            nxt_q.cnt = q_ff.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end
endmodule : tps_fifo

// ---- verilog/tps_pkg.sv ----
// tps_pkg: register map, field layout, reset values, modes and states
// of the synchronous tft panel timing output.
// assumes a single 20 mhz core clock and a plain strobe register port.
//
// Overview of operation
// - twenty-eight panel lines: line sync, frame sync, valid, clock, 24 colour bits.
// - red on top byte, green middle byte, blue lowest byte.
// - output colour depth selectable: 24, 18 or 16 bits.
// - eighteen-bit panels use only the lower 18 lines; upper six idle.
// - line sync marks end of line; following pixels belong to next line.
// - frame sync marks end of frame; panel restarts at first line.
// - while pixel valid is high the colour bus holds valid data.
// - each pixel clock pulse with valid high draws exactly one pixel.
// - valid lasts exactly the active width in pixel clocks per line.
// - high clock polarity: data changes on falling edge, latched rising.
// - low clock polarity: data changes on rising edge, latched falling.
// - either sync output may be left unused by the panel.
// - fixed panel timing, porches and polarities are reproduced exactly.
// - programmable pixel gaps before and after active pixels in a line.
// - programmable whole-line gaps before and after active lines.
// - line period equals active width plus both horizontal gaps.
// - sync polarity bit: zero is active low, one is active high.
package tps_pkg;
    localparam int TPS_FIELD_W = 12;
    localparam int TPS_FIFO_DEPTH = 8;
    // register byte offsets
    localparam logic [7:0] TPS_ADDR_CTRL = 8'h00;
    localparam logic [7:0] TPS_ADDR_HACT = 8'h04;
    localparam logic [7:0] TPS_ADDR_HGAP = 8'h08;
    localparam logic [7:0] TPS_ADDR_VACT = 8'h0C;
    localparam logic [7:0] TPS_ADDR_VGAP = 8'h10;
    localparam logic [7:0] TPS_ADDR_STAT = 8'h14;
    // control bit positions
    localparam int TPS_CTRL_EN = 0;
    localparam int TPS_CTRL_HS_POL = 1;
    localparam int TPS_CTRL_VS_POL = 2;
    localparam int TPS_CTRL_PC_POL = 3;
    localparam int TPS_CTRL_DEPTH = 4;
    localparam int TPS_CTRL_HS_EN = 6;
    localparam int TPS_CTRL_VS_EN = 7;
    // field positions inside timing and status words
    localparam int TPS_LO_POS = 0;
    localparam int TPS_HI_POS = 16;
    localparam int TPS_STAT_UNDER = 16;
    localparam int TPS_STAT_RUN = 17;
    // reset values
    localparam logic [7:0] TPS_CTRL_RST = 8'hC8;
    localparam logic [11:0] TPS_HACT_RST = 12'h280;
    localparam logic [11:0] TPS_HSW_RST = 12'h060;
    localparam logic [11:0] TPS_HLEAD_RST = 12'h030;
    localparam logic [11:0] TPS_HTRAIL_RST = 12'h010;
    localparam logic [11:0] TPS_VACT_RST = 12'h1E0;
    localparam logic [11:0] TPS_VSW_RST = 12'h001;
    localparam logic [11:0] TPS_VLEAD_RST = 12'h022;
    localparam logic [11:0] TPS_VTRAIL_RST = 12'h00B;

    typedef enum logic [1:0] {
        TPS_D24 = 2'h0,
        TPS_D18 = 2'h1,
        TPS_D16 = 2'h2
    } tps_depth_e;

    typedef enum logic [1:0] {
        TPS_IDLE = 2'b00,
        TPS_ARM = 2'b01,
        TPS_RUN = 2'b11
    } tps_state_e;
endpackage : tps_pkg

// ---- verilog/tps_sync3.sv ----
// tps_sync3: three-stage synchroniser for one asynchronous level.
// assumes the input toggles far slower than clk (pixel clock 400 ns).
`timescale 1ns/100ps
module tps_sync3 (
    input wire logic clk,
    input wire logic rst,
    input wire logic async_in,
    output logic level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } tps_sy_s;

    tps_sy_s sy_ff;
    tps_sy_s nxt_sy;

    // level only moves once stages two and three agree
    always_comb begin
        nxt_sy = sy_ff;
        nxt_sy.s1 = async_in;
        nxt_sy.s2 = sy_ff.s1;
        nxt_sy.s3 = sy_ff.s2;
        if (sy_ff.s2 == sy_ff.s3) begin
            nxt_sy.lvl = sy_ff.s3;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sy_ff <= '0;
        end else begin
            sy_ff <= nxt_sy;
        end
    end

    assign level = sy_ff.lvl;
endmodule : tps_sync3

// ---- verilog/tps_top.sv ----
// tps_top: raster timing and pixel output towards a synchronous tft panel.
// assumes pixel_clock is asynchronous and much slower than clk, and
// that software programs timing before setting the enable bit.
`timescale 1ns/100ps
module tps_top #(
    parameter int CNT_W = tps_pkg::TPS_FIELD_W,
    parameter int FIFO_DEPTH = tps_pkg::TPS_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic pixel_clock,
    input wire logic [23:0] pix_data,
    input wire logic pix_valid,
    output logic pix_ready,
    output logic line_pulse_pin,
    output logic frame_marker_pin,
    output logic pixel_valid_pin,
    output logic panel_clock_pin,
    output logic [23:0] colour_bus
);
    import tps_pkg::*;

    localparam int CW = CNT_W + 2;

    typedef struct packed {
        tps_state_e st;
        logic [7:0] ctrl;
        logic [CNT_W-1:0] h_act;
        logic [CNT_W-1:0] h_sw;
        logic [CNT_W-1:0] h_lead;
        logic [CNT_W-1:0] h_trail;
        logic [CNT_W-1:0] v_act;
        logic [CNT_W-1:0] v_sw;
        logic [CNT_W-1:0] v_lead;
        logic [CNT_W-1:0] v_trail;
        logic [CW-1:0] h_cnt;
        logic [CW-1:0] v_cnt;
        logic pclk;
        logic lp_pin;
        logic fm_pin;
        logic de;
        logic [23:0] colour;
        logic underrun;
        logic [31:0] rdata;
    } tps_top_s;

    tps_top_s s_ff;
    tps_top_s nxt_s;

    logic clk_lvl;
    logic launch;
    logic pop;
    logic fifo_valid;
    logic [23:0] fifo_data;
    logic [CW-1:0] h_tot;
    logic [CW-1:0] v_tot;
    logic [CW-1:0] nh;
    logic [CW-1:0] nv;
    logic in_h;
    logic in_v;
    logic hs_pol;
    logic vs_pol;

    // three-flop capture of the incoming pixel clock
    tps_sync3 u_pclk_sync (
        .clk(clk),
        .rst(rst),
        .async_in(pixel_clock),
        .level(clk_lvl)
    );

    // stalls the pixel source once every entry is full because the panel side is not draining
    tps_fifo #(
        .WIDTH(24),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(pix_valid),
        .in_ready(pix_ready),
        .in_data(pix_data),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_data)
    );

    // depth reduction keeps the msbs of each component, low-aligned
    function automatic logic [23:0] map_px(logic [23:0] d, logic [1:0] m);
        case (m)
            TPS_D18: map_px = {6'h00, d[23:18], d[15:10], d[7:2]};
            TPS_D16: map_px = {8'h00, d[23:19], d[15:10], d[7:3]};
            default: map_px = d;
        endcase
    endfunction : map_px

    // launch edge of the panel clock selects where data may change
    assign launch = s_ff.ctrl[TPS_CTRL_PC_POL] ? (s_ff.pclk & ~clk_lvl)
                                               : (~s_ff.pclk & clk_lvl);
    assign hs_pol = s_ff.ctrl[TPS_CTRL_HS_POL];
    assign vs_pol = s_ff.ctrl[TPS_CTRL_VS_POL];

    // line and frame periods from gaps plus active size
    assign h_tot = CW'(s_ff.h_lead) + CW'(s_ff.h_act) + CW'(s_ff.h_trail);
    assign v_tot = CW'(s_ff.v_lead) + CW'(s_ff.v_act) + CW'(s_ff.v_trail);

    // next raster position; first position after arming is the origin
    always_comb begin
        nh = '0;
        nv = '0;
        if (s_ff.st == TPS_RUN) begin
            if (s_ff.h_cnt >= h_tot - 1'b1) begin
                nh = '0;
                nv = (s_ff.v_cnt >= v_tot - 1'b1) ? '0 : s_ff.v_cnt + 1'b1;
            end else begin
                nh = s_ff.h_cnt + 1'b1;
                nv = s_ff.v_cnt;
            end
        end
    end

    // active window bounds measured from the sync starts
    assign in_h = (nh >= CW'(s_ff.h_lead)) && (nh < CW'(s_ff.h_lead) + CW'(s_ff.h_act));
    assign in_v = (nv >= CW'(s_ff.v_lead)) && (nv < CW'(s_ff.v_lead) + CW'(s_ff.v_act));

    // only drain the fifo on a launch edge inside the window
    assign pop = (s_ff.st != TPS_IDLE) && launch && in_h && in_v && s_ff.ctrl[TPS_CTRL_EN];

    // register port, timing state machine and pixel launch
    always_comb begin
        nxt_s = s_ff;
        nxt_s.pclk = clk_lvl;
        nxt_s.rdata = '0;
        // timing is software-set so fixed panels get their exact values
        if (reg_wr) begin
            case (reg_addr)
                TPS_ADDR_CTRL: nxt_s.ctrl = reg_wdata[7:0];
                TPS_ADDR_HACT: begin
                    nxt_s.h_act = reg_wdata[TPS_LO_POS +: CNT_W];
                    nxt_s.h_sw = reg_wdata[TPS_HI_POS +: CNT_W];
                end
                TPS_ADDR_HGAP: begin
                    nxt_s.h_lead = reg_wdata[TPS_LO_POS +: CNT_W];
                    nxt_s.h_trail = reg_wdata[TPS_HI_POS +: CNT_W];
                end
                TPS_ADDR_VACT: begin
                    nxt_s.v_act = reg_wdata[TPS_LO_POS +: CNT_W];
                    nxt_s.v_sw = reg_wdata[TPS_HI_POS +: CNT_W];
                end
                TPS_ADDR_VGAP: begin
                    nxt_s.v_lead = reg_wdata[TPS_LO_POS +: CNT_W];
                    nxt_s.v_trail = reg_wdata[TPS_HI_POS +: CNT_W];
                end
                TPS_ADDR_STAT: begin
                    if (reg_wdata[TPS_STAT_UNDER]) begin
                        nxt_s.underrun = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // unmapped addresses read zero
        if (reg_rd) begin
            case (reg_addr)
                TPS_ADDR_CTRL: nxt_s.rdata[7:0] = s_ff.ctrl;
                TPS_ADDR_HACT: begin
                    nxt_s.rdata[TPS_LO_POS +: CNT_W] = s_ff.h_act;
                    nxt_s.rdata[TPS_HI_POS +: CNT_W] = s_ff.h_sw;
                end
                TPS_ADDR_HGAP: begin
                    nxt_s.rdata[TPS_LO_POS +: CNT_W] = s_ff.h_lead;
                    nxt_s.rdata[TPS_HI_POS +: CNT_W] = s_ff.h_trail;
                end
                TPS_ADDR_VACT: begin
                    nxt_s.rdata[TPS_LO_POS +: CNT_W] = s_ff.v_act;
                    nxt_s.rdata[TPS_HI_POS +: CNT_W] = s_ff.v_sw;
                end
                TPS_ADDR_VGAP: begin
                    nxt_s.rdata[TPS_LO_POS +: CNT_W] = s_ff.v_lead;
                    nxt_s.rdata[TPS_HI_POS +: CNT_W] = s_ff.v_trail;
                end
                TPS_ADDR_STAT: begin
                    nxt_s.rdata[TPS_LO_POS +: CNT_W] = s_ff.v_cnt[CNT_W-1:0];
                    nxt_s.rdata[TPS_STAT_UNDER] = s_ff.underrun;
                    nxt_s.rdata[TPS_STAT_RUN] = (s_ff.st == TPS_RUN);
                end
                default: ;
            endcase
        end
        case (s_ff.st)
            TPS_IDLE: begin
                // quiet bus, inactive syncs at their programmed level
                nxt_s.de = 1'b0;
                nxt_s.colour = '0;
                nxt_s.lp_pin = ~hs_pol;
                nxt_s.fm_pin = ~vs_pol;
                nxt_s.h_cnt = '0;
                nxt_s.v_cnt = '0;
                if (s_ff.ctrl[TPS_CTRL_EN]) begin
                    nxt_s.st = TPS_ARM;
                end
            end
            TPS_ARM, TPS_RUN: begin
                if (!s_ff.ctrl[TPS_CTRL_EN]) begin
                    // valid drops with the state so it never outlives the run
                    nxt_s.st = TPS_IDLE;
                    nxt_s.de = 1'b0;
                end else if (launch) begin
                    // all pins move together on the launch edge
                    nxt_s.st = TPS_RUN;
                    nxt_s.h_cnt = nh;
                    nxt_s.v_cnt = nv;
                    nxt_s.lp_pin = ((nh < CW'(s_ff.h_sw)) && s_ff.ctrl[TPS_CTRL_HS_EN])
                                   ? hs_pol : ~hs_pol;
                    nxt_s.fm_pin = ((nv < CW'(s_ff.v_sw)) && s_ff.ctrl[TPS_CTRL_VS_EN])
                                   ? vs_pol : ~vs_pol;
                    nxt_s.de = in_h && in_v;
                    if (in_h && in_v) begin
                        // starved pixels go out black so timing never slips
                        nxt_s.colour = fifo_valid ? map_px(fifo_data, s_ff.ctrl[5:4]) : '0;
                    end else begin
                        nxt_s.colour = '0;
                    end
                end
            end
            default: nxt_s.st = TPS_IDLE;
        endcase
        // a starved pixel sets the flag after any clear, so set wins
        if (pop && !fifo_valid) begin
            nxt_s.underrun = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_ff <= '0;
            s_ff.st <= TPS_IDLE;
            s_ff.ctrl <= TPS_CTRL_RST;
            s_ff.h_act <= CNT_W'(TPS_HACT_RST);
            s_ff.h_sw <= CNT_W'(TPS_HSW_RST);
            s_ff.h_lead <= CNT_W'(TPS_HLEAD_RST);
            s_ff.h_trail <= CNT_W'(TPS_HTRAIL_RST);
            s_ff.v_act <= CNT_W'(TPS_VACT_RST);
            s_ff.v_sw <= CNT_W'(TPS_VSW_RST);
            s_ff.v_lead <= CNT_W'(TPS_VLEAD_RST);
            s_ff.v_trail <= CNT_W'(TPS_VTRAIL_RST);
            s_ff.lp_pin <= 1'b1;
            s_ff.fm_pin <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // twenty-eight panel lines, all from flops
    assign line_pulse_pin = s_ff.lp_pin;
    assign frame_marker_pin = s_ff.fm_pin;
    assign pixel_valid_pin = s_ff.de;
    assign panel_clock_pin = s_ff.pclk;
    assign colour_bus = s_ff.colour;
    assign reg_rdata = s_ff.rdata;

    // helper: launch edges seen while valid is high in the current run
    logic [CW-1:0] de_run_ff;
    always_ff @(posedge clk) begin
        if (rst || !pixel_valid_pin) begin
            de_run_ff <= '0;
        end else if (launch) begin
            de_run_ff <= de_run_ff + 1'b1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    valid_window_a: assert property (pixel_valid_pin |-> s_ff.st == TPS_RUN)
        else $error("pixel valid high outside running state");
    fall_launch_a: assert property ($changed(colour_bus) && $past(s_ff.st) == TPS_RUN
        && $past(s_ff.ctrl[TPS_CTRL_PC_POL]) |-> !panel_clock_pin)
        else $error("data moved off the falling panel clock edge");
    rise_launch_a: assert property ($changed(colour_bus) && $past(s_ff.st) == TPS_RUN
        && !$past(s_ff.ctrl[TPS_CTRL_PC_POL]) |-> panel_clock_pin)
        else $error("data moved off the rising panel clock edge");
    upper_idle_a: assert property ($changed(colour_bus)
        && $past(s_ff.ctrl[5:4]) == TPS_D18 |-> colour_bus[23:18] == 6'h00)
        else $error("upper colour lines driven in 18-bit mode");
    line_length_a: assert property ($fell(pixel_valid_pin) && s_ff.st == TPS_RUN
        && $stable(s_ff.h_act) |-> de_run_ff == CW'(s_ff.h_act))
        else $error("valid run differs from active width");
    line_wrap_a: assert property (s_ff.st == TPS_RUN && launch && s_ff.ctrl[TPS_CTRL_EN]
        && s_ff.h_cnt == h_tot - 1'b1 |=> s_ff.h_cnt == '0)
        else $error("line did not wrap at its period");
    lead_lines_a: assert property (s_ff.st == TPS_RUN
        && s_ff.v_cnt < CW'(s_ff.v_lead) |-> !pixel_valid_pin)
        else $error("valid high inside leading line gap");
    sync_idle_a: assert property (s_ff.st == TPS_IDLE && $stable(s_ff.ctrl)
        |=> line_pulse_pin == !$past(hs_pol) && frame_marker_pin == !$past(vs_pol))
        else $error("sync pins not at inactive level while idle");
    pixel_pass_a: assert property (pop && fifo_valid && s_ff.ctrl[5:4] == TPS_D24
        |=> colour_bus == $past(fifo_data) && pixel_valid_pin)
        else $error("24-bit pixel not passed unchanged");

    frame_wrap_c: cover property (launch && s_ff.v_cnt != '0 && nv == '0 && nh == '0);
    underrun_c: cover property ($rose(s_ff.underrun));
    depth18_c: cover property (pop && fifo_valid && s_ff.ctrl[5:4] == TPS_D18);
endmodule : tps_top
